// >>> verilog/relay_spi_consts.vh
`ifndef RELAY_SPI_CONSTS_VH
`define RELAY_SPI_CONSTS_VH

// ----------------------------------------
// Serial frame layout
// ----------------------------------------
`define FRAME_BITS 8
`define FRM_OP_BIT 7
`define FRM_ADDR_HI 6
`define FRM_ADDR_LO 4
`define FRM_DATA_HI 3
`define FRM_DATA_LO 0
`define FRM_BANK_BIT 0
`define FRM_RDREG_BIT 1
`define BANK_CONTROL 1'b0
`define BANK_DIAGNOSIS_BANK 1'b1

// ----------------------------------------
// Standard diagnosis answer layout
// ----------------------------------------
`define SD_AWAKE_BIT 5
`define SD_LIMP_BIT 4

// ----------------------------------------
// Control bank addresses and command bits
// ----------------------------------------
`define CTRL_REG_COUNT 6
`define CMD_ADDR 3'h6
`define CMD_WAKE_BIT 3
`define CMD_STB_BIT 2
`define CMD_RST_BIT 1
`define CMD_CPL_BIT 0
`define CTRL_DEFAULT 4'h0
`define DIAGNOSIS_BANK_REG_COUNT 4

// ----------------------------------------
// Software register port map (byte addresses)
// ----------------------------------------
`define RA_CTRL 8'h00
`define RA_STATUS 8'h04
`define RA_MASK 8'h08
`define RA_LINK 8'h0c
`define RA_CTRLREGS 8'h10
`define CTRL_RELOAD_BIT 0
`define ST_FRAME_OK 0
`define ST_FRAME_ERR 1
`define ST_CTRL_WRITE 2
`define ST_COMMAND 3
`define ST_WIDTH 4

`endif

// >>> verilog/relay_spi_frame.v
// Chosen here: the register addresses and the address-and-strobe port.
`include "relay_spi_consts.vh"

// Functional notes
// - Error flag on output before first clock rise
// - Flag zero when clock count nonzero multiple of eight
// - Flag one after failed frame or reset
// - Next frame shifts out the selected register
// - Command in answer frame still executes
// - Bank bit picks control or read-only diagnosis
// - Register pointer sits in bits 6:4
// - Four-bit payload sits in bits 3:0
// - Diagnosis answer: awake bit 5, alerts 3:0
// - Diagnosis bit 4 shows limp-home mode
// - Control defaults after reset, standby, reset command
// - Command bits self-clear; latch clear waits frame
module relay_spi_frame #(
   parameter ADDR_W = 8
) (
   input wire ref_clk,
   input wire rst_n,
   // Serial link pins
   input wire csN,
   input wire sclk,
   input wire si,
   output reg soData,
   output reg soEnN,
   // Device side
   input wire awakeIndication,
   input wire limpHomeActive,
   input wire [3:0] pairFailAlert,
   input wire [15:0] diagBankIn,
   output reg [23:0] controlBank,
   output reg clearLatchesBit,
   output reg standbyCommand,
   output reg wakeCommand,
   // Software port
   input wire [ADDR_W-1:0] regAddr,
   input wire [31:0] regWrData,
   input wire regWr,
   input wire regRd,
   output reg [31:0] regRdData,
   output reg irq
);

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   // Pick one nibble out of a packed bank
   function [3:0] nibbleOf;
      input [23:0] bank;
      input [2:0] idx;
      begin
         case (idx)
            3'h0: nibbleOf = bank[3:0];
            3'h1: nibbleOf = bank[7:4];
            3'h2: nibbleOf = bank[11:8];
            3'h3: nibbleOf = bank[15:12];
            3'h4: nibbleOf = bank[19:16];
            3'h5: nibbleOf = bank[23:20];
            default: nibbleOf = 4'h0;
         endcase
      end
   endfunction

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   reg [2:0] csSync_ff;
   reg [2:0] sclkSync_ff;
   reg [1:0] siSync_ff;

   // Chip select: two flops, third stage for edge finding only
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         csSync_ff <= 3'h7;
      end else begin
         csSync_ff <= {csSync_ff[1:0], csN};
      end
   end

   // Serial clock: two flops, third stage for edge finding only
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         sclkSync_ff <= 3'h0;
      end else begin
         sclkSync_ff <= {sclkSync_ff[1:0], sclk};
      end
   end

   // Serial data: two flops
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         siSync_ff <= 2'h0;
      end else begin
         siSync_ff <= {siSync_ff[0], si};
      end
   end

   wire csLow = ~csSync_ff[1];
   wire csFall = csSync_ff[2] & ~csSync_ff[1];
   wire csRise = ~csSync_ff[2] & csSync_ff[1];
   wire sclkRise = csLow & ~sclkSync_ff[2] & sclkSync_ff[1];
   wire sclkFall = csLow & sclkSync_ff[2] & ~sclkSync_ff[1];
   wire siBit = siSync_ff[1];

   // ----------------------------------------
   // Frame state
   // ----------------------------------------
   reg [7:0] rxShift_ff;
   reg [7:0] txShift_ff;
   reg [7:0] clkCount_ff;
   reg terFlag_ff;
   reg rdPending_ff;
   reg rdBank_ff;
   reg [2:0] rdAddr_ff;
   reg [7:0] lastFrame_ff;
   reg reload_ff;
   reg [`ST_WIDTH-1:0] status_ff;
   reg [`ST_WIDTH-1:0] mask_ff;

   // ----------------------------------------
   // Frame decode
   // ----------------------------------------
   // Good frame: a nonzero multiple of eight clocks
   wire frameValid = (clkCount_ff[2:0] == 3'h0) && (clkCount_ff != 8'h0);
   wire isWrite = rxShift_ff[`FRM_OP_BIT];
   wire [2:0] rxAddr = rxShift_ff[`FRM_ADDR_HI:`FRM_ADDR_LO];
   wire [3:0] rxData = rxShift_ff[`FRM_DATA_HI:`FRM_DATA_LO];
   wire execFrame = csRise & frameValid;
   wire ctrlWrite = execFrame & isWrite & (rxAddr < `CMD_ADDR);
   wire cmdWrite = execFrame & isWrite & (rxAddr == `CMD_ADDR);
   wire cmdReload = cmdWrite & (rxData[`CMD_STB_BIT] | rxData[`CMD_RST_BIT]);

   // ----------------------------------------
   // Answer byte
   // ----------------------------------------
   // Read data or standard diagnosis for the coming frame
   reg [7:0] nxt_answer;
   reg [3:0] readNibble;
   always @* begin
      readNibble = 4'h0;
      nxt_answer = 8'h00;
      if (rdPending_ff) begin
         if (rdBank_ff == `BANK_DIAGNOSIS_BANK) begin
            if (rdAddr_ff < `DIAGNOSIS_BANK_REG_COUNT) begin
               readNibble = diagBankIn[rdAddr_ff[1:0]*4 +: 4];
            end
         end else begin
            readNibble = nibbleOf(controlBank, rdAddr_ff);
         end
         nxt_answer[`FRM_ADDR_HI:`FRM_ADDR_LO] = rdAddr_ff;
         nxt_answer[`FRM_DATA_HI:`FRM_DATA_LO] = readNibble;
      end else begin
         nxt_answer[`SD_AWAKE_BIT] = awakeIndication;
         nxt_answer[`SD_LIMP_BIT] = limpHomeActive;
         nxt_answer[3:0] = pairFailAlert;
      end
      nxt_answer[`FRM_OP_BIT] = terFlag_ff;
   end

   // ----------------------------------------
   // Shifting and output pin
   // ----------------------------------------
   // Past the eighth clock the output repeats the input, eight bits late
   wire chainBit = (clkCount_ff >= `FRAME_BITS) ? rxShift_ff[7] : txShift_ff[6];

   // Receive on clock rise, transmit on clock fall
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rxShift_ff <= 8'h00;
         txShift_ff <= 8'h00;
         clkCount_ff <= 8'h00;
         soData <= 1'b0;
         soEnN <= 1'b1;
      end else if (csFall) begin
         txShift_ff <= nxt_answer;
         soData <= nxt_answer[7];
         soEnN <= 1'b0;
         clkCount_ff <= 8'h00;
      end else if (csRise) begin
         soEnN <= 1'b1;
      end else begin
         if (sclkRise) begin
            rxShift_ff <= {rxShift_ff[6:0], siBit};
            if (clkCount_ff != 8'hff) begin
               clkCount_ff <= clkCount_ff + 8'h01;
            end
         end
         if (sclkFall) begin
            // Daisy chain: received bits follow our own answer
            txShift_ff <= {txShift_ff[6:0], 1'b0};
            soData <= chainBit;
         end
      end
   end

   // ----------------------------------------
   // Error flag and pending read
   // ----------------------------------------
   // Flag holds one until a good frame closes; a reload wins
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         terFlag_ff <= 1'b1;
      end else if (reload_ff) begin
         terFlag_ff <= 1'b1;
      end else if (csRise) begin
         terFlag_ff <= ~frameValid;
      end
   end

   // A good read frame arms the answer of the next frame
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdPending_ff <= 1'b0;
         rdBank_ff <= `BANK_CONTROL;
         rdAddr_ff <= 3'h0;
         lastFrame_ff <= 8'h00;
      end else if (csRise) begin
         lastFrame_ff <= rxShift_ff;
         if (frameValid && !isWrite && !reload_ff && rxShift_ff[`FRM_RDREG_BIT]) begin
            rdPending_ff <= 1'b1;
            rdBank_ff <= rxShift_ff[`FRM_BANK_BIT];
            rdAddr_ff <= rxAddr;
         end else begin
            rdPending_ff <= 1'b0;
         end
      end else if (reload_ff) begin
         rdPending_ff <= 1'b0;
      end
   end

   // ----------------------------------------
   // Control bank and commands
   // ----------------------------------------
   // Writes land in the control bank only
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         controlBank <= {6{`CTRL_DEFAULT}};
      end else if (cmdReload || reload_ff) begin
         controlBank <= {6{`CTRL_DEFAULT}};
      end else if (ctrlWrite) begin
         controlBank[rxAddr*4 +: 4] <= rxData;
      end
   end

   // Command pulses last one clock
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         standbyCommand <= 1'b0;
         wakeCommand <= 1'b0;
      end else begin
         standbyCommand <= cmdWrite & rxData[`CMD_STB_BIT];
         wakeCommand <= cmdWrite & rxData[`CMD_WAKE_BIT];
      end
   end

   // Latch clear waits for the next good frame; a new set wins
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         clearLatchesBit <= 1'b0;
      end else if (cmdWrite && rxData[`CMD_CPL_BIT]) begin
         clearLatchesBit <= 1'b1;
      end else if (execFrame || reload_ff) begin
         clearLatchesBit <= 1'b0;
      end
   end

   // ----------------------------------------
   // Software register port
   // ----------------------------------------
   wire [`ST_WIDTH-1:0] events = {cmdWrite, ctrlWrite, csRise & ~frameValid, execFrame};
   wire wrStatus = regWr && (regAddr == `RA_STATUS);
   wire wrMask = regWr && (regAddr == `RA_MASK);
   wire wrCtrl = regWr && (regAddr == `RA_CTRL);
   // Link state word for software
   wire [31:0] linkWord = {7'h0, clearLatchesBit, clkCount_ff, lastFrame_ff,
                           2'h0, rdBank_ff, rdAddr_ff, rdPending_ff, terFlag_ff};

   // Sticky status, set beats write-one clear
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         status_ff <= {`ST_WIDTH{1'b0}};
      end else if (wrStatus) begin
         status_ff <= (status_ff & ~regWrData[`ST_WIDTH-1:0]) | events;
      end else begin
         status_ff <= status_ff | events;
      end
   end

   // Interrupt mask, same layout as status
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         mask_ff <= {`ST_WIDTH{1'b0}};
      end else if (wrMask) begin
         mask_ff <= regWrData[`ST_WIDTH-1:0];
      end
   end

   // Software reload strobe, one clock after the write
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         reload_ff <= 1'b0;
      end else begin
         reload_ff <= wrCtrl && regWrData[`CTRL_RELOAD_BIT];
      end
   end

   // Level interrupt while an unmasked event is pending
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq <= 1'b0;
      end else begin
         irq <= |(status_ff & mask_ff);
      end
   end

   // Read multiplexer, zero when no read
   reg [31:0] nxt_rdData;
   always @* begin
      nxt_rdData = 32'h0;
      if (regRd) begin
         case (regAddr)
            `RA_STATUS: nxt_rdData = {28'h0, status_ff};
            `RA_MASK: nxt_rdData = {28'h0, mask_ff};
            `RA_LINK: nxt_rdData = linkWord;
            `RA_CTRLREGS: nxt_rdData = {8'h0, controlBank};
            default: nxt_rdData = 32'h0;
         endcase
      end
   end

   // Read data one cycle after the strobe
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         regRdData <= 32'h0;
      end else begin
         regRdData <= nxt_rdData;
      end
   end

endmodule // relay_spi_frame

// >>> tb/relay_spi_frame_properties.sv
module relay_spi_frame_checker (
   input wire ref_clk,
   input wire rst_n,
   input wire csN,
   input wire soEnN,
   input wire [23:0] controlBank,
   input wire clearLatchesBit,
   input wire standbyCommand,
   input wire wakeCommand,
   input wire regWr
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // Output enable follows chip select
   so_idle_off_a: assert property (csN [*5] |-> soEnN)
      else $error("so driven outside frame");
   so_drive_on_a: assert property ($fell(csN) |-> ##[2:6] !soEnN)
      else $error("so not driven after select");
   // Command pulses and their effects
   stb_pulse_a: assert property (standbyCommand |=> !standbyCommand)
      else $error("standby pulse too long");
   wake_pulse_a: assert property (wakeCommand |=> !wakeCommand)
      else $error("wake pulse too long");
   stb_reload_a: assert property (standbyCommand |-> ##[0:2] controlBank == 24'h0)
      else $error("standby did not reload defaults");
   cmd_frame_end_a: assert property ((standbyCommand || wakeCommand) |-> csN)
      else $error("command executed inside frame");
   latch_set_a: assert property ($rose(clearLatchesBit) |-> csN)
      else $error("latch clear set inside frame");
   bank_hold_a: assert property ((!csN && !regWr) [*4] |=> $stable(controlBank))
      else $error("control bank changed mid frame");
endmodule // relay_spi_frame_checker

bind relay_spi_frame relay_spi_frame_checker chk (.ref_clk(ref_clk), .rst_n(rst_n),
   .csN(csN), .soEnN(soEnN), .controlBank(controlBank), .clearLatchesBit(clearLatchesBit),
   .standbyCommand(standbyCommand), .wakeCommand(wakeCommand), .regWr(regWr));

// >>> tb/spi_master_model.sv
module spi_master_model (
   input wire ref_clk,
   input wire soData,
   input wire soEnN,
   output logic csN,
   output logic sclk,
   output logic si,
   output logic [7:0] rxByte,
   output logic rxValid
);
   timeunit 1ns;
   timeprecision 1ps;
   // Released line shows the inverse, so early sampling is caught
   wire soLine = soEnN ? ~soData : soData;
   // Idle levels of pulled pins
   initial begin
      csN = 1'b1;
      sclk = 1'b0;
      si = 1'b0;
      rxByte = 8'h00;
      rxValid = 1'b0;
   end
   // One frame of n clocks, 200 ns clock period
   task automatic frame(input logic [7:0] tx, input int n);
      @(posedge ref_clk) csN <= 1'b0;
      repeat (4) @(posedge ref_clk);
      for (int i = 0; i < n; i++) begin
         si <= (i < 8) ? tx[7-i] : 1'b0;
         repeat (4) @(posedge ref_clk);
         sclk <= 1'b1;
         if (i < 8) rxByte[7-i] <= soLine;
         repeat (4) @(posedge ref_clk);
         sclk <= 1'b0;
      end
      repeat (4) @(posedge ref_clk);
      csN <= 1'b1;
      si <= 1'b0;
      rxValid <= (n == 8);
      @(posedge ref_clk) rxValid <= 1'b0;
      repeat (8) @(posedge ref_clk);
   endtask
endmodule // spi_master_model

// >>> tb/testbench.sv
`include "relay_spi_consts.vh"
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin failCount++; \
   $display("Error t=%0t got %h exp %h", $time, a, e); end end
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk, rst_n, csN, sclk, si, soData, soEnN, awake_indication, limp, rxValid, rdDly, pb;
   logic clrLatch, stbCmd, wakeCmd, regWr, regRd, irq;
   logic [3:0] alerts;
   logic [15:0] diagBank;
   logic [23:0] ctrlBank, ctrlExp;
   logic [7:0] regAddr, rxByte;
   logic [2:0] ra, pa;
   logic [31:0] regWrData, regRdData, x;
   logic [31:0] expQ[$];
   int failCount, checked, seed, stbCount, wakeCount;
   relay_spi_frame DUT (.ref_clk(ref_clk), .rst_n(rst_n), .csN(csN), .sclk(sclk), .si(si),
      .soData(soData), .soEnN(soEnN), .awakeIndication(awake_indication), .limpHomeActive(limp),
      .pairFailAlert(alerts), .diagBankIn(diagBank), .controlBank(ctrlBank),
      .clearLatchesBit(clrLatch), .standbyCommand(stbCmd), .wakeCommand(wakeCmd),
      .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
      .regRdData(regRdData), .irq(irq));
   spi_master_model m (.ref_clk(ref_clk), .soData(soData), .soEnN(soEnN), .csN(csN), .sclk(sclk),
      .si(si), .rxByte(rxByte), .rxValid(rxValid));
   // Clock
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   // Result watcher
   always @(posedge ref_clk) begin
      rdDly <= regRd;
      if (stbCmd) stbCount++;
      if (wakeCmd) wakeCount++;
      if (rdDly || rxValid) begin
         x = expQ.pop_front();
         if (rdDly) `CHK(regRdData, x)
         else `CHK({24'h0, rxByte}, x)
      end
   end
   function automatic logic [7:0] sd(input logic t);
      return {t, 1'b0, awake_indication, limp, alerts};
   endfunction
   task automatic fr(input logic [7:0] tx, input logic [7:0] ex);
      expQ.push_back({24'h0, ex});
      m.frame(tx, 8);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      regAddr <= a;
      regWrData <= d;
      regWr <= 1'b1;
      @(posedge ref_clk) regWr <= 1'b0;
      repeat (2) @(posedge ref_clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] ex);
      expQ.push_back(ex);
      @(posedge ref_clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge ref_clk) regRd <= 1'b0;
      repeat (2) @(posedge ref_clk);
   endtask
   task automatic close_out();
      $display("checked %0d mismatches %0d", checked, failCount);
      if (failCount == 0 && checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // Watchdog
   initial begin
      repeat (20000) @(posedge ref_clk);
      failCount++;
      close_out();
   end
   // Main sequence
   initial begin
      seed = 32'h34830f17;
      {rst_n, regWr, regRd, regAddr, regWrData} = '0;
      {awake_indication, limp, alerts} = 6'($random(seed));
      diagBank = 16'($random(seed));
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge ref_clk);
      fr(8'h00, sd(1));
      fr(8'h00, sd(0));
      $display("test error flag done");
      for (int a = 0; a < 6; a++) begin
         ctrlExp[4*a +: 4] = 4'($random(seed));
         fr({1'b1, 3'(a), ctrlExp[4*a +: 4]}, sd(0));
      end
      `CHK(ctrlBank, ctrlExp)
      for (int k = 0; k <= 10; k++) begin
         ra = 3'((k < 6) ? k : k - 6);
         fr((k < 10) ? {1'b0, ra, 3'b001, k >= 6} : 8'h00, (k == 0) ? sd(0) :
            {1'b0, pa, pb ? diagBank[4*pa +: 4] : ctrlExp[4*pa +: 4]});
         pa = ra;
         pb = k >= 6;
      end
      $display("test chained reads done");
      fr(8'h02, sd(0));
      m.frame(8'h8f, 7);
      fr(8'h00, sd(1));
      `CHK(ctrlBank, ctrlExp)
      for (int c = 0; c < 4; c++) begin
         fr(8'h85, sd(0));
         `CHK(clrLatch, 1'b0)
         fr({4'he, 4'h1 << c}, sd(0));
         `CHK(ctrlBank, (c == 1 || c == 2) ? 24'h0 : {ctrlExp[23:4], 4'h5})
         if (c == 0) `CHK(clrLatch, 1'b1)
         if (c == 1) ctrlExp = 24'h0;
      end
      `CHK(stbCount, 1)
      `CHK(wakeCount, 1)
      $display("test commands done");
      wr(`RA_STATUS, 32'hf);
      wr(`RA_MASK, 32'h0);
      fr(8'h00, sd(0));
      rd(`RA_STATUS, 32'h1);
      `CHK(irq, 1'b0)
      wr(`RA_MASK, 32'h1);
      `CHK(irq, 1'b1)
      wr(`RA_STATUS, 32'h1);
      `CHK(irq, 1'b0)
      rd(8'h14, 32'h0);
      wr(`RA_CTRL, 32'h1);
      `CHK(ctrlBank, 24'h0)
      fr(8'hf0, sd(1));
      rd(`RA_LINK, 32'h0008f000);
      m.frame(8'h00, 9);
      fr(8'h85, sd(1));
      fr(8'he0, sd(0));
      rd(`RA_STATUS, 32'hf);
      rd(`RA_CTRLREGS, 32'h5);
      `CHK(irq, 1'b1)
      $display("test registers done");
      close_out();
   end
endmodule // testbench
